/* pxc_ext_regs_regs.svh */
/*
 * Register indices, field positions and reset values of the extended
 * control bank. Assumes the includer uses these names only.
 */
`ifndef PXC_EXT_REGS_REGS_SVH
`define PXC_EXT_REGS_REGS_SVH

// Word index taken from the byte address
`define PXC_IDX_MSB        9
`define PXC_IDX_LSB        2
`define PXC_HTRANS_ACT     1

// Register indices, byte address is four times the index
`define PXC_IDX_CTL4       8'h17
`define PXC_IDX_RSVA       8'h18
`define PXC_IDX_RSVB       8'h19
`define PXC_IDX_RSVC       8'h1A
`define PXC_IDX_CTL5       8'h1B
`define PXC_IDX_SWRST      8'h20
`define PXC_IDX_ISTAT      8'h21
`define PXC_IDX_IMASK      8'h22

// Control four fields
`define PXC_C4_ADDR_MSB    15
`define PXC_C4_ADDR_LSB    11
`define PXC_C4_PDEN        10
`define PXC_C4_PDST_MSB    9
`define PXC_C4_PDST_LSB    8
`define PXC_C4_CNT_MSB     7
`define PXC_C4_CNT_LSB     0

// Control five fields
`define PXC_C5_MDIX        15
`define PXC_C5_RSVD        14
`define PXC_C5_CRS_MSB     13
`define PXC_C5_CRS_LSB     12
`define PXC_C5_MEM         11
`define PXC_C5_LPBK        10
`define PXC_C5_RPWR        9
`define PXC_C5_A100_MSB    8
`define PXC_C5_A100_LSB    6
`define PXC_C5_A1G_MSB     5
`define PXC_C5_A1G_LSB     3
`define PXC_C5_EDGE_MSB    2
`define PXC_C5_EDGE_LSB    0

// Carrier sense selector bits
`define PXC_CRS_RXONLY_BIT 1
`define PXC_CRS_FDOFF_BIT  0

// Software reset and interrupt layout
`define PXC_SWRST_BIT      0
`define PXC_EV_CRC         0
`define PXC_EV_SAT         1
`define PXC_EV_DET         2
`define PXC_EV_MEM         3

// Reset values
`define PXC_RST_PDEN       1'h0
`define PXC_RST_MDIX       1'h1
`define PXC_RST_CRS        2'h0
`define PXC_RST_LPBK       1'h0
`define PXC_RST_RPWR       1'h0
`define PXC_RST_A100       3'h6
`define PXC_RST_A1G        3'h0
`define PXC_RST_EDGE       3'h7
`define PXC_RST_ADDR       5'h00
`define PXC_RST_IRQ        4'h0
`define PXC_RST_CNT        8'h00
`define PXC_CNT_MAX        8'hFF

`endif

/* pxc_pkg.sv */
/*
 * Types shared by the extended control bank.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package pxc_pkg;
    // Inline power detection progress codes
    typedef enum logic [1:0] {
        PXC_DET_SEARCH    = 2'b00,
        PXC_DET_NEEDS_PWR = 2'b01,
        PXC_DET_NO_PWR    = 2'b10,
        PXC_DET_RSVD      = 2'b11
    } pxc_det_e;

    typedef logic [15:0] pxc_word_t;
endpackage : pxc_pkg
`default_nettype wire

/* pxc_sat_counter.sv */
/*
 * Saturating event counter with a synchronous clear.
 * Assumes inc and clear are synchronous to clk.
 */
`timescale 1ns/10ps
`default_nettype none
module pxc_sat_counter #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // Control
    input  wire logic             inc,
    input  wire logic             clear,
    // Result
    output logic [WIDTH-1:0]      count,
    output logic                  sat_pulse
);
    localparam logic [WIDTH-1:0] CNT_ONE  = {{(WIDTH-1){1'b0}}, 1'b1};
    localparam logic [WIDTH-1:0] CNT_MAX  = {WIDTH{1'b1}};
    localparam logic [WIDTH-1:0] CNT_NEAR = CNT_MAX - CNT_ONE;

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic             sat_reg;
    wire              at_max  = (count_reg == CNT_MAX);
    wire              sat_hit = inc & ~clear & (count_reg == CNT_NEAR);

    // An error in the clearing cycle counts as the first of the new run
    assign count_next = clear  ? (inc ? CNT_ONE : '0) :
                        (inc & ~at_max) ? count_reg + CNT_ONE : count_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_reg <= '0;
            sat_reg   <= 1'b0;
        end else begin
            count_reg <= count_next;
            sat_reg   <= sat_hit;
        end
    end

    assign count     = count_reg;
    assign sat_pulse = sat_reg;
endmodule : pxc_sat_counter
`default_nettype wire

/* pxc_ext_regs.sv */
/*
 * Extended control and status bank of the copper PHY, as an AHB-Lite
 * slave: station address, inline power detection, generator CRC error
 * count, carrier sense selection and transmitter tuning codes.
 * Assumes one master, single word transfers, and that every PHY-side
 * input is synchronous to hclk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pxc_ext_regs_regs.svh"

module pxc_ext_regs (
    // AHB-Lite clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Straps and status from the PHY core
    input  wire logic [4:0]  config_strap_pins,
    input  wire logic        cfg_mem_present,
    input  wire logic [1:0]  pd_det_status,
    input  wire logic        packet_generator_crc_err,
    // MAC side carrier sense inputs, and the forced speed flag for crossover
    input  wire logic        full_duplex,
    input  wire logic        speed_forced,
    input  wire logic        rx_dv,
    input  wire logic        tx_en,
    // Controls to the PHY core
    output logic             crs,
    output logic             auto_mdix_off,
    output logic             pd_detect_en,
    output logic             far_end_loopback,
    output logic             reduced_power,
    output logic [2:0]       tx_amp_100,
    output logic [2:0]       tx_amp_1g,
    output logic [2:0]       edge_rate_1g,
    // Interrupt
    output logic             irq
);

    function automatic logic pxc_hit(input logic [7:0] a, input logic [7:0] b);
        pxc_hit = (a == b);
    endfunction : pxc_hit

    // Bus tracking
    logic [7:0]          idx_reg;
    logic                wr_pend_reg;
    logic                rd_pend_reg;
    logic [31:0]         hrdata_reg;

    // Hardware-reset-only state
    logic [4:0]          phy_addr_reg;
    logic                strap_done_reg;
    logic                pd_en_reg;
    logic                mdix_dis_reg;
    logic [1:0]          crs_sel_reg;
    logic                rpwr_reg;
    logic [2:0]          amp100_reg;
    logic [2:0]          edge_reg;

    // State that any reset returns to default
    logic                lpbk_reg;
    logic [2:0]          amp1g_reg;

    // Output and event state
    logic                crs_reg;
    logic                mdix_off_reg;
    pxc_pkg::pxc_det_e   pd_prev_reg;
    logic                mem_prev_reg;
    logic [3:0]          irq_stat_reg;
    logic [3:0]          irq_stat_next;
    logic [3:0]          irq_mask_reg;
    logic [3:0]          irq_mask_next;
    logic                irq_reg;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // Address phase decode
    wire                 bus_take = hsel & hready & htrans[`PXC_HTRANS_ACT];
    wire [7:0]           a_idx    = haddr[`PXC_IDX_MSB:`PXC_IDX_LSB];

    // Data phase decode on the held index
    wire                 hit_c4   = pxc_hit(idx_reg, `PXC_IDX_CTL4);
    wire                 hit_c5   = pxc_hit(idx_reg, `PXC_IDX_CTL5);
    wire                 hit_sw   = pxc_hit(idx_reg, `PXC_IDX_SWRST);
    wire                 hit_stat = pxc_hit(idx_reg, `PXC_IDX_ISTAT);
    wire                 hit_mask = pxc_hit(idx_reg, `PXC_IDX_IMASK);
    wire                 hit_rsvd = pxc_hit(idx_reg, `PXC_IDX_RSVA) |
                                    pxc_hit(idx_reg, `PXC_IDX_RSVB) |
                                    pxc_hit(idx_reg, `PXC_IDX_RSVC);

    wire                 wr_c4    = wr_pend_reg & hit_c4;
    wire                 wr_c5    = wr_pend_reg & hit_c5;
    wire                 wr_mask  = wr_pend_reg & hit_mask;
    wire                 rd_c4    = rd_pend_reg & hit_c4;
    wire                 rd_c5    = rd_pend_reg & hit_c5;
    wire                 rd_stat  = rd_pend_reg & hit_stat;
    wire                 rd_rsvd  = rd_pend_reg & hit_rsvd;

    // Write data fields
    wire                 wd_pden  = hwdata[`PXC_C4_PDEN];
    wire                 wd_mdix  = hwdata[`PXC_C5_MDIX];
    wire [1:0]           wd_crs   = hwdata[`PXC_C5_CRS_MSB:`PXC_C5_CRS_LSB];
    wire                 wd_lpbk  = hwdata[`PXC_C5_LPBK];
    wire                 wd_rpwr  = hwdata[`PXC_C5_RPWR];
    wire [2:0]           wd_a100  = hwdata[`PXC_C5_A100_MSB:`PXC_C5_A100_LSB];
    wire [2:0]           wd_a1g   = hwdata[`PXC_C5_A1G_MSB:`PXC_C5_A1G_LSB];
    wire [2:0]           wd_edge  = hwdata[`PXC_C5_EDGE_MSB:`PXC_C5_EDGE_LSB];
    wire                 swrst    = wr_pend_reg & hit_sw & hwdata[`PXC_SWRST_BIT];

    // Reads stall one cycle so a write just before lands first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx_reg     <= 8'h00;
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
        end else begin
            wr_pend_reg <= bus_take & hwrite;
            rd_pend_reg <= bus_take & ~hwrite;
            if (bus_take) begin
                idx_reg <= a_idx;
            end
        end
    end

    assign hreadyout = ~rd_pend_reg;
    assign hresp     = 1'b0;

    AST_READ_WAIT: assert property (rd_pend_reg |-> !hreadyout ##1 hreadyout)
        else $error("read data phase not exactly one wait state");

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phy_addr_reg   <= `PXC_RST_ADDR;
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            phy_addr_reg   <= config_strap_pins;
            strap_done_reg <= 1'b1;
        end
    end

    AST_STRAP_HOLD: assert property (strap_done_reg |=> $stable(phy_addr_reg))
        else $error("station address changed after capture");

    // sticky fields on hardware reset only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pd_en_reg    <= `PXC_RST_PDEN;
            mdix_dis_reg <= `PXC_RST_MDIX;
            crs_sel_reg  <= `PXC_RST_CRS;
            rpwr_reg     <= `PXC_RST_RPWR;
            amp100_reg   <= `PXC_RST_A100;
            edge_reg     <= `PXC_RST_EDGE;
        end else begin
            if (wr_c4) begin
                pd_en_reg <= wd_pden;
            end
            if (wr_c5) begin
                mdix_dis_reg <= wd_mdix;
                crs_sel_reg  <= wd_crs;
                rpwr_reg     <= wd_rpwr;
                amp100_reg   <= wd_a100;
                edge_reg     <= wd_edge;
            end
        end
    end

    // plain fields also reset by software
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lpbk_reg  <= `PXC_RST_LPBK;
            amp1g_reg <= `PXC_RST_A1G;
        end else if (swrst) begin
            lpbk_reg  <= `PXC_RST_LPBK;
            amp1g_reg <= `PXC_RST_A1G;
        end else if (wr_c5) begin
            lpbk_reg  <= wd_lpbk;
            amp1g_reg <= wd_a1g;
        end
    end

    AST_PDEN_WRITE: assert property (wr_c4 |=> pd_detect_en == $past(wd_pden))
        else $error("detection enable did not take written value");
    AST_RPWR_WRITE: assert property (wr_c5 |=> reduced_power == $past(wd_rpwr))
        else $error("reduced power enable did not take written value");
    AST_EDGE_WRITE: assert property (wr_c5 |=> edge_rate_1g == $past(wd_edge))
        else $error("edge rate code did not take written value");
    AST_AMP_STICKY: assert property (swrst |=> $stable(tx_amp_100))
        else $error("amplitude code lost on software reset");
    AST_SOFT_DEFAULT: assert property (swrst |=> !far_end_loopback ##0 tx_amp_1g == 3'h0)
        else $error("plain field kept value over software reset");

    wire                 cnt_clear = rd_c4 | swrst;
    wire [7:0]           cnt_val;
    wire                 sat_pulse;

    pxc_sat_counter #(
        .WIDTH     (8)
    ) u_crc_cnt (
        .clk       (hclk),
        .rstn      (hresetn),
        .inc       (packet_generator_crc_err),
        .clear     (cnt_clear),
        .count     (cnt_val),
        .sat_pulse (sat_pulse)
    );

    AST_CNT_SAT: assert property ((cnt_val == `PXC_CNT_MAX) && !cnt_clear
                                  |=> cnt_val == `PXC_CNT_MAX)
        else $error("CRC error count wrapped");
    AST_CNT_CLR: assert property (rd_c4 && !packet_generator_crc_err
                                  |=> cnt_val == `PXC_RST_CNT)
        else $error("CRC error count not cleared by read");

    // crossover off only while speed is forced
    wire                 crs_half = crs_sel_reg[`PXC_CRS_RXONLY_BIT] ? rx_dv : (rx_dv | tx_en);
    wire                 crs_full = crs_sel_reg[`PXC_CRS_FDOFF_BIT] ? 1'b0 : rx_dv;
    wire                 crs_next = full_duplex ? crs_full : crs_half;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            crs_reg      <= 1'b0;
            mdix_off_reg <= 1'b0;
        end else begin
            crs_reg      <= crs_next;
            mdix_off_reg <= mdix_dis_reg & speed_forced;
        end
    end

    AST_MDIX_FORCED: assert property (speed_forced && mdix_dis_reg |=> auto_mdix_off)
        else $error("crossover not disabled in forced speed");
    AST_CRS_HALF: assert property (!full_duplex && !crs_sel_reg[`PXC_CRS_RXONLY_BIT] && tx_en
                                   |=> crs)
        else $error("half duplex carrier sense missed transmit enable");
    AST_CRS_FULL: assert property (full_duplex && crs_sel_reg[`PXC_CRS_FDOFF_BIT]
                                   |=> !crs)
        else $error("full duplex carrier sense not held low");

    // Sticky events, status read clears, a new event wins over the clear
    wire [3:0]           ev;
    assign ev[`PXC_EV_CRC] = packet_generator_crc_err;
    assign ev[`PXC_EV_SAT] = sat_pulse;
    // change only flagged while detection is enabled
    assign ev[`PXC_EV_DET] = pd_en_reg & (pd_det_status != pd_prev_reg);
    // A memory already present at release is not a new arrival
    assign ev[`PXC_EV_MEM] = strap_done_reg & cfg_mem_present & ~mem_prev_reg;
    assign irq_stat_next   = (irq_stat_reg & ~{4{rd_stat}}) | ev;
    // Next mask feeds irq so a mask write takes effect without a lag
    assign irq_mask_next   = wr_mask ? hwdata[`PXC_EV_MEM:`PXC_EV_CRC] : irq_mask_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pd_prev_reg  <= pxc_pkg::PXC_DET_SEARCH;
            mem_prev_reg <= 1'b0;
            irq_stat_reg <= `PXC_RST_IRQ;
            irq_mask_reg <= `PXC_RST_IRQ;
            irq_reg      <= 1'b0;
        end else begin
            pd_prev_reg  <= pxc_pkg::pxc_det_e'(pd_det_status);
            mem_prev_reg <= cfg_mem_present;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            irq_reg      <= |(irq_stat_next & irq_mask_next);
        end
    end

    AST_IRQ_CRC: assert property (packet_generator_crc_err && irq_mask_reg[`PXC_EV_CRC]
                                  && !wr_mask |=> irq)
        else $error("unmasked event did not raise interrupt");

    // Read words
    pxc_pkg::pxc_word_t  c4_word;
    pxc_pkg::pxc_word_t  c5_word;
    pxc_pkg::pxc_word_t  rd_word;

    assign c4_word[`PXC_C4_ADDR_MSB:`PXC_C4_ADDR_LSB] = phy_addr_reg;
    assign c4_word[`PXC_C4_PDEN]                      = pd_en_reg;
    assign c4_word[`PXC_C4_PDST_MSB:`PXC_C4_PDST_LSB] = pd_det_status;
    assign c4_word[`PXC_C4_CNT_MSB:`PXC_C4_CNT_LSB]   = cnt_val;

    // memory presence and control five layout
    assign c5_word[`PXC_C5_MDIX]                      = mdix_dis_reg;
    assign c5_word[`PXC_C5_RSVD]                      = 1'b0;
    assign c5_word[`PXC_C5_CRS_MSB:`PXC_C5_CRS_LSB]   = crs_sel_reg;
    assign c5_word[`PXC_C5_MEM]                       = cfg_mem_present;
    assign c5_word[`PXC_C5_LPBK]                      = lpbk_reg;
    assign c5_word[`PXC_C5_RPWR]                      = rpwr_reg;
    assign c5_word[`PXC_C5_A100_MSB:`PXC_C5_A100_LSB] = amp100_reg;
    assign c5_word[`PXC_C5_A1G_MSB:`PXC_C5_A1G_LSB]   = amp1g_reg;
    assign c5_word[`PXC_C5_EDGE_MSB:`PXC_C5_EDGE_LSB] = edge_reg;

    // reserved slots and unmapped indices read zero
    assign rd_word = hit_c4   ? c4_word :
                     hit_c5   ? c5_word :
                     hit_stat ? {12'h000, irq_stat_reg} :
                     hit_mask ? {12'h000, irq_mask_reg} :
                     16'h0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h00000000;
        end else if (rd_pend_reg) begin
            hrdata_reg <= {16'h0000, rd_word};
        end
    end

    AST_RSVD_ZERO: assert property (rd_rsvd |=> hrdata == 32'h00000000)
        else $error("reserved slot read nonzero");
    AST_DET_READ: assert property (rd_c4 |=> hrdata[`PXC_C4_PDST_MSB:`PXC_C4_PDST_LSB]
                                   == $past(pd_det_status))
        else $error("detection status misreported");
    AST_MEM_READ: assert property (rd_c5 |=> hrdata[`PXC_C5_MEM]
                                   == $past(cfg_mem_present))
        else $error("memory presence misreported");

    // Output drive
    assign hrdata           = hrdata_reg;
    assign crs              = crs_reg;
    assign auto_mdix_off    = mdix_off_reg;
    assign pd_detect_en     = pd_en_reg;
    assign far_end_loopback = lpbk_reg;
    assign reduced_power    = rpwr_reg;
    assign tx_amp_100       = amp100_reg;
    assign tx_amp_1g        = amp1g_reg;
    assign edge_rate_1g     = edge_reg;
    assign irq              = irq_reg;

endmodule : pxc_ext_regs
`default_nettype wire

/* pxc_ext_regs_tb.sv */
/*
 * Self-checking bench of the extended control bank: register access,
 * error counter, carrier sense, resets and interrupt.
 * Assumes the bank is the one slave, its hreadyout fed back as hready.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pxc_ext_regs_regs.svh"
module pxc_ext_regs_tb;
    localparam logic [31:0] A_CTL4  = {22'h0, `PXC_IDX_CTL4, 2'h0};
    localparam logic [31:0] A_RSVA  = {22'h0, `PXC_IDX_RSVA, 2'h0};
    localparam logic [31:0] A_CTL5  = {22'h0, `PXC_IDX_CTL5, 2'h0};
    localparam logic [31:0] A_SWRST = {22'h0, `PXC_IDX_SWRST, 2'h0};
    localparam logic [31:0] A_ISTAT = {22'h0, `PXC_IDX_ISTAT, 2'h0};
    localparam logic [31:0] A_IMASK = {22'h0, `PXC_IDX_IMASK, 2'h0};
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, det;
    logic [2:0]  hsize, amp100, amp1g, edge1g;
    logic [4:0]  straps;
    logic        mem, crc_err, fd, forced, rx_dv, tx_en;
    logic        crs, mdix_off, pd_en, lpbk, rpwr, irq;
    int          miscompares, cmp_count, cycles;

    assign hready = hreadyout;

    pxc_ext_regs u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .config_strap_pins(straps), .cfg_mem_present(mem), .pd_det_status(det),
        .packet_generator_crc_err(crc_err), .full_duplex(fd), .speed_forced(forced),
        .rx_dv(rx_dv), .tx_en(tx_en), .crs(crs), .auto_mdix_off(mdix_off),
        .pd_detect_en(pd_en), .far_end_loopback(lpbk), .reduced_power(rpwr),
        .tx_amp_100(amp100), .tx_amp_1g(amp1g), .edge_rate_1g(edge1g), .irq(irq)
    );

    always #50 hclk = ~hclk;

    task automatic test_done;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    // Hangs inside a bus wait end here
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            miscompares++;
        end
    endtask : chk

    // Address phase held until hready, data phase held until hready again
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
        chk(32'(hresp), 32'h0);
    endtask : xfer

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask : wr

    task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask : rchk

    // Error strobe held high for n edges gives n events
    task automatic pulse(input int n);
        @(posedge hclk);
        crc_err <= 1'b1;
        repeat (n) @(posedge hclk);
        crc_err <= 1'b0;
    endtask : pulse

    task automatic t_reset_vals;
        straps <= 5'h0A;
        rchk(A_CTL4, 32'hA900);
        rchk(A_CTL5, 32'h8187);
        chk(32'({mdix_off, pd_en, edge1g}), 32'h17);
    endtask : t_reset_vals

    task automatic t_ctl4;
        wr(A_CTL4, 32'hFFFF);
        rchk(A_CTL4, 32'hAD00);
        chk(32'(pd_en), 32'h1);
        for (int i = 0; i < 4; i++) begin
            @(posedge hclk);
            det <= 2'(i);
            rchk(A_CTL4, 32'hAC00 | (32'(i) << 8));
        end
    endtask : t_ctl4

    task automatic t_crc;
        pulse(3);
        rchk(A_CTL4, 32'hAF03);
        rchk(A_CTL4, 32'hAF00);
        pulse(260);
        rchk(A_CTL4, 32'hAFFF);
        rchk(A_CTL4, 32'hAF00);
    endtask : t_crc

    task automatic t_reserved;
        logic [31:0] a;
        for (int i = 0; i < 4; i++) begin
            a = (i == 3) ? 32'h70 : A_RSVA + 32'(4 * i);
            wr(a, 32'hFFFF);
            rchk(a, 32'h0);
        end
    endtask : t_reserved

    task automatic t_ctl5;
        wr(A_CTL5, 32'h5EAB);
        rchk(A_CTL5, 32'h16AB);
        chk(32'({lpbk, rpwr, amp100, amp1g, edge1g}), 32'h6AB);
        chk(32'(mdix_off), 32'h0);
        @(posedge hclk);
        mem <= 1'b1;
        rchk(A_CTL5, 32'h1EAB);
        wr(A_CTL5, 32'h96AB);
        repeat (2) @(posedge hclk);
        chk(32'(mdix_off), 32'h1);
        forced <= 1'b0;
        repeat (2) @(posedge hclk);
        chk(32'(mdix_off), 32'h0);
    endtask : t_ctl5

    task automatic t_crs;
        logic e;
        for (int s = 0; s < 4; s++) begin
            wr(A_CTL5, 32'h8187 | (32'(s) << 12));
            for (int k = 0; k < 8; k++) begin
                @(posedge hclk);
                fd    <= k[2];
                rx_dv <= k[1];
                tx_en <= k[0];
                repeat (2) @(posedge hclk);
                e = k[2] ? (s[0] ? 1'b0 : k[1]) : (s[1] ? k[1] : k[1] | k[0]);
                chk(32'(crs), 32'(e));
            end
        end
    endtask : t_crs

    task automatic t_resets;
        wr(A_CTL5, 32'h96AB);
        pulse(2);
        wr(A_SWRST, 32'h1);
        rchk(A_CTL5, 32'h9A83);
        rchk(A_CTL4, 32'hAF00);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(A_CTL5, 32'h8987);
        rchk(A_CTL4, 32'h5300);
    endtask : t_resets

    task automatic t_irq;
        rchk(A_ISTAT, 32'h0);
        wr(A_IMASK, 32'h0);
        pulse(1);
        repeat (2) @(posedge hclk);
        chk(32'(irq), 32'h0);
        rchk(A_ISTAT, 32'h1);
        wr(A_IMASK, 32'hF);
        rchk(A_IMASK, 32'hF);
        pulse(1);
        repeat (2) @(posedge hclk);
        chk(32'(irq), 32'h1);
        rchk(A_ISTAT, 32'h1);
        chk(32'(irq), 32'h0);
    endtask : t_irq

    initial begin
        hclk        = 1'b0;
        hresetn     = 1'b0;
        hsel        = 1'b0;
        haddr       = 32'h00000000;
        htrans      = 2'h0;
        hwrite      = 1'b0;
        hsize       = 3'h2;
        hwdata      = 32'h00000000;
        straps      = 5'h15;
        mem         = 1'b0;
        det         = 2'h1;
        crc_err     = 1'b0;
        fd          = 1'b0;
        forced      = 1'b1;
        rx_dv       = 1'b0;
        tx_en       = 1'b0;
        miscompares = 0;
        cmp_count   = 0;
        cycles      = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset_vals();
        t_ctl4();
        t_crc();
        t_reserved();
        t_ctl5();
        t_crs();
        t_resets();
        t_irq();
        test_done();
    end
endmodule : pxc_ext_regs_tb
`default_nettype wire
